// ---- rtl/tmr16_core.sv ----
/*
 16-bit timer core behind an 8-bit CPU I/O port: prescaler reset bit,
 counter, two double-buffered compares, capture with noise filter,
 shared high-byte temporary register, flag and mask registers.
 Assumes a single-cycle I/O read/write strobe from the CPU on I_CLOCK.
*/
// What this block does
// - Prescaler reset bit restarts shared prescaler
// - Hardware clears prescaler reset bit itself
// - Writing zero to reset bit: no effect
// - Prescaler reset bit always reads zero
// - Count, compares, capture are 16-bit, two bytes
// - Both control registers accessed directly
// - Four events set flags, masked individually
// - No clock selected keeps counter stopped
// - Compares checked on every timer tick, set match flags
// - Capture event copies counter to capture unless capture is TOP
// - Selectable noise filter on capture trigger
// - Compare A as TOP in modes 9/b/f: buffered, no output
// - TOP fixed 0xff/0x1ff/0x3ff, compare A, capture
// - BOTTOM is 0x0000, MAX is 0xffff
// - One shared 8-bit temporary high byte
// - Low write loads temp high and low
// - Low read latches high into temp
// - Compare reads bypass temporary register
// - Host counter write beats clear or count
// - Prescaler taps divide by 8/64/256/1024
`timescale 1ns/100ps
`include "tmr16_defines.svh"

module tmr16_core (
	input  wire logic                    I_CLOCK,
	input  wire logic                    I_RST_B,
	input  wire logic [`TMR16_ADDR_W-1:0] I_ADDR,
	input  wire logic                    I_WR,
	input  wire logic                    I_RD,
	input  wire tmr16_pkg::tmr16_byte_t  I_WDATA,
	input  wire logic                    I_EXTERNAL_COUNT_PIN,
	input  wire logic                    I_CAPTURE_PIN,
	input  wire logic                    I_COMPARATOR_OUT,
	input  wire logic                    I_CAPT_SRC_COMP,
	output tmr16_pkg::tmr16_byte_t       O_RDATA,
	output logic                         O_WAVE_OUT_A,
	output logic                         O_WAVE_OUT_B,
	output logic                         O_IRQ
);
	import tmr16_pkg::*;

	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	tmr16_byte_t   ctrl_a_r, ctrl_b_r, mask_r, flag_r, temp_r, misc_r;
	tmr16_word_t   cnt_r, cmpa_r, cmpb_r, cmpa_buf_r, cmpb_buf_r, capt_r;
	logic          psr_r;
	logic [`TMR16_NC_LEN-1:0] nc_r;
	logic          nc_lvl_r, trig_prev_r;
	tmr16_byte_t   rdata_nxt;
	logic          tap8, tap64, tap256, tap1024;
	logic          ext_rise, ext_fall;
	logic          icp_lvl, pin_lvl, acmp_lvl;
	logic          tick, wr_cnt, pwm_cmpa_top, trig_raw, trig_evt;
	logic [3:0]    wgm;
	tmr16_word_t   top;
	tmr16_cs_e     cs;

	// Address strobe decode, used for every register strobe except the temp_r high-byte writes
	function automatic logic hit(input logic stb, input logic [`TMR16_ADDR_W-1:0] a,
		input logic [`TMR16_ADDR_W-1:0] t);
		return stb && (a == t);
	endfunction

	// ---------------------------------------------------------------
	// Prescaler and pin synchronisers
	// ---------------------------------------------------------------
	tmr16_presc u_presc (
		.i_clk       (I_CLOCK),
		.i_rst_b     (I_RST_B),
		.i_presc_clr (psr_r),
		.o_tap8      (tap8),
		.o_tap64     (tap64),
		.o_tap256    (tap256),
		.o_tap1024   (tap1024)
	);

	tmr16_sync u_ext (
		.i_clk   (I_CLOCK),
		.i_rst_b (I_RST_B),
		.i_pin   (I_EXTERNAL_COUNT_PIN),
		.o_level (),
		.o_rise  (ext_rise),
		.o_fall  (ext_fall)
	);

	// Both trigger sources synchronised ahead of the select: no raw pin feeds logic
	tmr16_sync u_icp (.i_clk(I_CLOCK), .i_rst_b(I_RST_B), .i_pin(I_CAPTURE_PIN),
		.o_level(pin_lvl), .o_rise(), .o_fall());
	tmr16_sync u_acmp (.i_clk(I_CLOCK), .i_rst_b(I_RST_B), .i_pin(I_COMPARATOR_OUT),
		.o_level(acmp_lvl), .o_rise(), .o_fall());

	// ---------------------------------------------------------------
	// Timer tick, TOP and mode decode
	// ---------------------------------------------------------------
	always_comb begin
		cs   = tmr16_cs_e'(ctrl_b_r[2:0]);
		wgm  = {ctrl_b_r[4:3], ctrl_a_r[1:0]};
		unique case (cs)
			TMR16_CS_STOP:     tick = 1'b0;
			TMR16_CS_DIV1:     tick = 1'b1;
			TMR16_CS_DIV8:     tick = tap8;
			TMR16_CS_DIV64:    tick = tap64;
			TMR16_CS_DIV256:   tick = tap256;
			TMR16_CS_DIV1024:  tick = tap1024;
			TMR16_CS_EXT_FALL: tick = ext_fall;
			TMR16_CS_EXT_RISE: tick = ext_rise;
		endcase
		// Only modes that give TOP are decoded; others wrap at MAX
		unique case (wgm)
			4'h1, 4'h5:        top = `TMR16_TOP8;
			4'h2, 4'h6:        top = `TMR16_TOP9;
			4'h3, 4'h7:        top = `TMR16_TOP10;
			4'h4, 4'h9, 4'hb, 4'hf: top = cmpa_r;
			4'h8, 4'ha, 4'hc, 4'he: top = capt_r;
			default:           top = `TMR16_MAX;
		endcase
		pwm_cmpa_top = (wgm == 4'h9) || (wgm == 4'hb) || (wgm == 4'hf);
		wr_cnt = hit(I_WR, I_ADDR, `TMR16_A_CNT_L);
	end

	// ---------------------------------------------------------------
	// Prescaler reset bit: self-clearing one-cycle request
	// ---------------------------------------------------------------
	always_ff @(posedge I_CLOCK) begin
		if (!I_RST_B)
			psr_r <= 1'b0;
		else
			psr_r <= hit(I_WR, I_ADDR, `TMR16_A_MISC_CTRL) && I_WDATA[`TMR16_B_PSR];
	end

	// Other misc bits just store; reset bit kept out
	always_ff @(posedge I_CLOCK) begin
		if (!I_RST_B)
			misc_r <= `TMR16_RST8;
		else if (hit(I_WR, I_ADDR, `TMR16_A_MISC_CTRL))
			misc_r <= I_WDATA & ~(8'h01 << `TMR16_B_PSR);
	end

	// ---------------------------------------------------------------
	// Control and mask registers
	// ---------------------------------------------------------------
	always_ff @(posedge I_CLOCK) begin
		if (!I_RST_B) begin
			ctrl_a_r <= `TMR16_RST8;
			ctrl_b_r <= `TMR16_RST8;
			mask_r   <= `TMR16_RST8;
		end else begin
			if (hit(I_WR, I_ADDR, `TMR16_A_CTRL_A))
				ctrl_a_r <= I_WDATA;
			if (hit(I_WR, I_ADDR, `TMR16_A_CTRL_B))
				ctrl_b_r <= I_WDATA;
			if (hit(I_WR, I_ADDR, `TMR16_A_MASK))
				mask_r <= I_WDATA;
		end
	end

	// ---------------------------------------------------------------
	// Shared temporary high byte
	// ---------------------------------------------------------------
	always_ff @(posedge I_CLOCK) begin
		if (!I_RST_B)
			temp_r <= `TMR16_RST8;
		else if (I_WR && (I_ADDR == `TMR16_A_CNT_H || I_ADDR == `TMR16_A_CMPA_H ||
			I_ADDR == `TMR16_A_CMPB_H || I_ADDR == `TMR16_A_CAPT_H))
			temp_r <= I_WDATA;
		else if (hit(I_RD, I_ADDR, `TMR16_A_CNT_L))
			temp_r <= cnt_r[15:8];
		else if (hit(I_RD, I_ADDR, `TMR16_A_CAPT_L))
			temp_r <= capt_r[15:8];
	end

	// ---------------------------------------------------------------
	// Counter: host write wins over count and clear
	// ---------------------------------------------------------------
	always_ff @(posedge I_CLOCK) begin
		if (!I_RST_B)
			cnt_r <= `TMR16_RST16;
		else if (wr_cnt)
			cnt_r <= {temp_r, I_WDATA};
		else if (tick)
			cnt_r <= (cnt_r == top) ? `TMR16_BOTTOM : cnt_r + 16'h0001;
	end

	// ---------------------------------------------------------------
	// Compare buffers, update at TOP when buffered by mode
	// ---------------------------------------------------------------
	always_ff @(posedge I_CLOCK) begin
		if (!I_RST_B) begin
			cmpa_buf_r <= `TMR16_RST16;
			cmpb_buf_r <= `TMR16_RST16;
			cmpa_r     <= `TMR16_RST16;
			cmpb_r     <= `TMR16_RST16;
		end else begin
			if (hit(I_WR, I_ADDR, `TMR16_A_CMPA_L))
				cmpa_buf_r <= {temp_r, I_WDATA};
			if (hit(I_WR, I_ADDR, `TMR16_A_CMPB_L))
				cmpb_buf_r <= {temp_r, I_WDATA};
			// Non-PWM modes load at once; PWM modes wait for TOP
			if (wgm == 4'h0 || wgm == 4'h4 || wgm == 4'hc || (tick && cnt_r == top)) begin
				cmpa_r <= cmpa_buf_r;
				cmpb_r <= cmpb_buf_r;
			end
		end
	end

	// ---------------------------------------------------------------
	// Capture trigger with optional noise filter
	// ---------------------------------------------------------------
	// Filter needs the level stable for several cycles; costs latency
	always_ff @(posedge I_CLOCK) begin
		if (!I_RST_B) begin
			nc_r        <= '0;
			nc_lvl_r    <= 1'b0;
			trig_prev_r <= 1'b0;
		end else begin
			nc_r        <= {nc_r[`TMR16_NC_LEN-2:0], icp_lvl};
			if (&nc_r)
				nc_lvl_r <= 1'b1;
			else if (~|nc_r)
				nc_lvl_r <= 1'b0;
			trig_prev_r <= trig_raw;
		end
	end

	always_comb begin
		icp_lvl  = I_CAPT_SRC_COMP ? acmp_lvl : pin_lvl;
		trig_raw = ctrl_b_r[`TMR16_B_NOISE] ? nc_lvl_r : icp_lvl;
		trig_evt = ctrl_b_r[`TMR16_B_EDGE] ? (trig_raw & ~trig_prev_r) : (~trig_raw & trig_prev_r);
	end

	// Capture value: event copies counter unless it is TOP, host may load it as TOP
	always_ff @(posedge I_CLOCK) begin
		if (!I_RST_B)
			capt_r <= `TMR16_RST16;
		else if (trig_evt && !(top == capt_r && wgm[3]))
			capt_r <= cnt_r;
		else if (hit(I_WR, I_ADDR, `TMR16_A_CAPT_L))
			capt_r <= {temp_r, I_WDATA};
	end

	// ---------------------------------------------------------------
	// Flags: set wins over write-one-to-clear
	// ---------------------------------------------------------------
	always_ff @(posedge I_CLOCK) begin
		if (!I_RST_B)
			flag_r <= `TMR16_RST8;
		else begin
			for (int i = 0; i < 8; i++) begin
				if (hit(I_WR, I_ADDR, `TMR16_A_FLAG) && I_WDATA[i])
					flag_r[i] <= 1'b0;
			end
			if (tick && cnt_r == top && !wr_cnt)
				flag_r[`TMR16_B_OVF] <= 1'b1;
			if (tick && cnt_r == cmpa_r && !wr_cnt)
				flag_r[`TMR16_B_MATCH_A] <= 1'b1;
			if (tick && cnt_r == cmpb_r && !wr_cnt)
				flag_r[`TMR16_B_MATCH_B] <= 1'b1;
			if (trig_evt)
				flag_r[`TMR16_B_CAPT] <= 1'b1;
		end
	end

	// ---------------------------------------------------------------
	// Waveforms, interrupt and read data
	// ---------------------------------------------------------------
	always_ff @(posedge I_CLOCK) begin
		if (!I_RST_B) begin
			O_WAVE_OUT_A <= 1'b0;
			O_WAVE_OUT_B <= 1'b0;
			O_IRQ        <= 1'b0;
		end else begin
			O_WAVE_OUT_A <= !pwm_cmpa_top && (cnt_r < cmpa_r);
			O_WAVE_OUT_B <= (cnt_r < cmpb_r);
			O_IRQ        <= |(flag_r & mask_r & `TMR16_FLAG_MASK);
		end
	end

	always_comb begin
		rdata_nxt = `TMR16_RST8;
		unique case (I_ADDR)
			`TMR16_A_MISC_CTRL: rdata_nxt = misc_r;
			`TMR16_A_CTRL_A:    rdata_nxt = ctrl_a_r;
			`TMR16_A_CTRL_B:    rdata_nxt = ctrl_b_r;
			`TMR16_A_CNT_L:     rdata_nxt = cnt_r[7:0];
			`TMR16_A_CNT_H:     rdata_nxt = temp_r;
			`TMR16_A_CMPA_L:    rdata_nxt = cmpa_buf_r[7:0];
			`TMR16_A_CMPA_H:    rdata_nxt = cmpa_buf_r[15:8];
			`TMR16_A_CMPB_L:    rdata_nxt = cmpb_buf_r[7:0];
			`TMR16_A_CMPB_H:    rdata_nxt = cmpb_buf_r[15:8];
			`TMR16_A_CAPT_L:    rdata_nxt = capt_r[7:0];
			`TMR16_A_CAPT_H:    rdata_nxt = temp_r;
			`TMR16_A_MASK:      rdata_nxt = mask_r;
			`TMR16_A_FLAG:      rdata_nxt = flag_r;
			default:            rdata_nxt = `TMR16_RST8;
		endcase
	end

	// Read data registered, one cycle after the strobe
	always_ff @(posedge I_CLOCK) begin
		if (!I_RST_B)
			O_RDATA <= `TMR16_RST8;
		else if (I_RD)
			O_RDATA <= rdata_nxt;
	end

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	sequence psr_write_s;
		hit(I_WR, I_ADDR, `TMR16_A_MISC_CTRL) && I_WDATA[`TMR16_B_PSR];
	endsequence

	psr_self_clear_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_B)
		psr_write_s |=> psr_r ##1 !psr_r) else $error("prescaler reset not self-cleared");
	psr_zero_write_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_B)
		(hit(I_WR, I_ADDR, `TMR16_A_MISC_CTRL) && !I_WDATA[`TMR16_B_PSR]) |=> !psr_r)
		else $error("zero write triggered prescaler reset");
	psr_reads_zero_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_B)
		hit(I_RD, I_ADDR, `TMR16_A_MISC_CTRL) |=> !O_RDATA[`TMR16_B_PSR])
		else $error("prescaler reset bit read as one");
	cnt_stopped_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_B)
		(cs == TMR16_CS_STOP && !wr_cnt) |=> $stable(cnt_r)) else $error("counter moved with no clock");
	cnt_write_wins_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_B)
		wr_cnt |=> cnt_r == {$past(temp_r), $past(I_WDATA)}) else $error("counter write lost");
	temp_latch_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_B)
		hit(I_RD, I_ADDR, `TMR16_A_CNT_L) && !I_WR |=> temp_r == $past(cnt_r[15:8]))
		else $error("temp not loaded on low read");
	capture_copy_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_B)
		(trig_evt && !wgm[3]) |=> capt_r == $past(cnt_r) && flag_r[`TMR16_B_CAPT])
		else $error("capture missed");
	match_a_flag_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_B)
		(tick && cnt_r == cmpa_r && !wr_cnt) |=> flag_r[`TMR16_B_MATCH_A])
		else $error("compare A match flag not set");
	presc_tap_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_B)
		psr_r |=> !tap8[*7] ##1 tap8) else $error("divide by 8 tap wrong");
endmodule

// ---- rtl/tmr16_defines.svh ----
/*
 Address map, field positions, reset values and count limits of the
 16-bit timer core. Assumes the CPU I/O port gives a 6-bit I/O address.
*/
`ifndef TMR16_DEFINES_SVH
`define TMR16_DEFINES_SVH

// ---------------------------------------------------------------
// I/O addresses
// ---------------------------------------------------------------
`define TMR16_ADDR_W       6
`define TMR16_A_MISC_CTRL  6'h30
`define TMR16_A_CTRL_A     6'h2f
`define TMR16_A_CTRL_B     6'h2e
`define TMR16_A_CNT_H      6'h2d
`define TMR16_A_CNT_L      6'h2c
`define TMR16_A_CMPA_H     6'h2b
`define TMR16_A_CMPA_L     6'h2a
`define TMR16_A_CMPB_H     6'h29
`define TMR16_A_CMPB_L     6'h28
`define TMR16_A_CAPT_H     6'h25
`define TMR16_A_CAPT_L     6'h24
`define TMR16_A_MASK       6'h39
`define TMR16_A_FLAG       6'h38

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define TMR16_B_PSR        0
`define TMR16_B_OVF        7
`define TMR16_B_MATCH_A    6
`define TMR16_B_MATCH_B    5
`define TMR16_B_CAPT       3
`define TMR16_B_NOISE      7
`define TMR16_B_EDGE       6

// ---------------------------------------------------------------
// Values
// ---------------------------------------------------------------
`define TMR16_RST8         8'h00
`define TMR16_RST16        16'h0000
`define TMR16_BOTTOM       16'h0000
`define TMR16_MAX          16'hffff
`define TMR16_TOP8         16'h00ff
`define TMR16_TOP9         16'h01ff
`define TMR16_TOP10        16'h03ff
`define TMR16_FLAG_MASK    8'he8
`define TMR16_PRESC_W      10
`define TMR16_NC_LEN       4

`endif

// ---- rtl/tmr16_pkg.sv ----
/*
 Types of the 16-bit timer core.
 Assumes tmr16_defines.svh is available on the include path.
*/
package tmr16_pkg;
	// Clock select codes
	typedef enum logic [2:0] {
		TMR16_CS_STOP, TMR16_CS_DIV1, TMR16_CS_DIV8, TMR16_CS_DIV64,
		TMR16_CS_DIV256, TMR16_CS_DIV1024, TMR16_CS_EXT_FALL, TMR16_CS_EXT_RISE
	} tmr16_cs_e;
	typedef logic [15:0] tmr16_word_t;
	typedef logic [7:0]  tmr16_byte_t;
endpackage

// ---- rtl/tmr16_presc.sv ----
/*
 Shared free-running prescaler with 8/64/256/1024 taps.
 Assumes a single system clock; reset request comes from the register file.
*/
`timescale 1ns/100ps
`include "tmr16_defines.svh"

module tmr16_presc (
	input  wire logic       i_clk,
	input  wire logic       i_rst_b,
	input  wire logic       i_presc_clr,
	output logic            o_tap8,
	output logic            o_tap64,
	output logic            o_tap256,
	output logic            o_tap1024
);
	logic [`TMR16_PRESC_W-1:0] cnt_r;

	// Free running; a clear restarts every tap
	always_ff @(posedge i_clk) begin
		if (!i_rst_b || i_presc_clr)
			cnt_r <= '0;
		else
			cnt_r <= cnt_r + 1'b1;
	end

	// Tap pulses one cycle wide at the wrap of each divider
	always_comb begin
		o_tap8    = &cnt_r[2:0];
		o_tap64   = &cnt_r[5:0];
		o_tap256  = &cnt_r[7:0];
		o_tap1024 = &cnt_r[9:0];
	end
endmodule

// ---- rtl/tmr16_sync.sv ----
/*
 Two-flop synchroniser with edge detect for an external pin.
 Assumes the pin is asynchronous to the system clock.
*/
`timescale 1ns/100ps

module tmr16_sync (
	input  wire logic i_clk,
	input  wire logic i_rst_b,
	input  wire logic i_pin,
	output logic      o_level,
	output logic      o_rise,
	output logic      o_fall
);
	logic meta_r;
	logic sync_r;
	logic prev_r;

	// First flop only feeds the second
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			meta_r <= 1'b0;
			sync_r <= 1'b0;
			prev_r <= 1'b0;
		end else begin
			meta_r <= i_pin;
			sync_r <= meta_r;
			prev_r <= sync_r;
		end
	end

	always_comb begin
		o_level = sync_r;
		o_rise  = sync_r & ~prev_r;
		o_fall  = ~sync_r & prev_r;
	end
endmodule

// ---- verification/timer16_core_and_byte_access_bench.sv ----
/*
 Self-checking bench of the 16-bit timer core, driven through the CPU model.
 Assumes the core's register map and strobe timing from the defines header.
*/
`timescale 1ns/100ps
`include "tmr16_defines.svh"

module timer16_core_and_byte_access_bench;
	import tmr16_pkg::*;
	localparam int LIMIT = 50000;
	logic        clk = 1'b0;
	logic        rst_b = 1'b0;
	logic        ext_pin = 1'b0;
	logic        capt_pin = 1'b0;
	logic        comp_out = 1'b0;
	logic        src_comp = 1'b0;
	logic [5:0]  addr;
	logic        wr;
	logic        rd;
	tmr16_byte_t wdata;
	tmr16_byte_t rdata;
	logic        wave_a;
	logic        wave_b;
	logic        irq;
	int          err_total = 0;
	int          num_checks = 0;
	int          cycles = 0;
	tmr16_word_t w;

	// Clock
	always #25 clk = ~clk;

	tmr16_core dut (.I_CLOCK(clk), .I_RST_B(rst_b), .I_ADDR(addr), .I_WR(wr), .I_RD(rd),
		.I_WDATA(wdata), .I_EXTERNAL_COUNT_PIN(ext_pin), .I_CAPTURE_PIN(capt_pin),
		.I_COMPARATOR_OUT(comp_out), .I_CAPT_SRC_COMP(src_comp), .O_RDATA(rdata),
		.O_WAVE_OUT_A(wave_a), .O_WAVE_OUT_B(wave_b), .O_IRQ(irq));
	tmr16_cpu_model cpu (.i_clk(clk), .i_rdata(rdata), .o_addr(addr), .o_wr(wr), .o_rd(rd), .o_wdata(wdata));

	// ----------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------
	task automatic run(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic chk(input string s, input tmr16_word_t e, input tmr16_word_t g);
		num_checks++;
		if (g !== e) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", s, e, g);
		end
	endtask

	task automatic chkr(input string s, input int lo, input int hi, input tmr16_word_t g);
		num_checks++;
		if ($isunknown(g) || g < lo || g > hi) begin
			err_total++;
			$display("MISMATCH %s expected %0d..%0d seen %0d", s, lo, hi, g);
		end
	endtask

	task automatic rdc(input string s, input logic [5:0] a, input tmr16_byte_t e);
		tmr16_byte_t v;
		cpu.io_rd(a, v);
		chk(s, e, v);
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// ----------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------
	task automatic t_reset();
		rdc("misc", `TMR16_A_MISC_CTRL, 8'h00);
		rdc("ctrl_a", `TMR16_A_CTRL_A, 8'h00);
		rdc("ctrl_b", `TMR16_A_CTRL_B, 8'h00);
		rdc("flag", `TMR16_A_FLAG, 8'h00);
		rdc("mask", `TMR16_A_MASK, 8'h00);
		rdc("unmapped", 6'h00, 8'h00);
		cpu.rd16(`TMR16_A_CNT_L, w);
		chk("count", 16'h0000, w);
		$display("t_reset done");
	endtask

	// Repeated prescaler restarts keep a /1024 timer from ever ticking
	task automatic t_presc();
		cpu.io_wr(`TMR16_A_MISC_CTRL, 8'h01);
		rdc("reset bit", `TMR16_A_MISC_CTRL, 8'h00);
		cpu.io_wr(`TMR16_A_MISC_CTRL, 8'h00);
		rdc("zero write", `TMR16_A_MISC_CTRL, 8'h00);
		cpu.io_wr(`TMR16_A_CTRL_B, 8'h05);
		repeat (6) begin
			cpu.io_wr(`TMR16_A_MISC_CTRL, 8'h01);
			run(500);
		end
		cpu.io_wr(`TMR16_A_CTRL_B, 8'h00);
		cpu.rd16(`TMR16_A_CNT_L, w);
		chk("held count", 16'h0000, w);
		$display("t_presc done");
	endtask

	task automatic t_bytes();
		cpu.wr16(`TMR16_A_CNT_L, 16'h1234);
		cpu.io_wr(`TMR16_A_CNT_H, 8'hab);
		rdc("cnt low", `TMR16_A_CNT_L, 8'h34);
		rdc("cnt high", `TMR16_A_CNT_H, 8'h12);
		cpu.io_wr(`TMR16_A_CMPA_H, 8'h56);
		cpu.io_wr(`TMR16_A_CNT_L, 8'h78);
		cpu.rd16(`TMR16_A_CNT_L, w);
		chk("shared temp", 16'h5678, w);
		cpu.wr16(`TMR16_A_CMPA_L, 16'h9abc);
		cpu.io_wr(`TMR16_A_CNT_H, 8'h11);
		rdc("cmpa high", `TMR16_A_CMPA_H, 8'h9a);
		rdc("cmpa low", `TMR16_A_CMPA_L, 8'hbc);
		rdc("temp kept", `TMR16_A_CNT_H, 8'h11);
		cpu.wr16(`TMR16_A_CMPB_L, 16'hfedc);
		rdc("cmpb high", `TMR16_A_CMPB_H, 8'hfe);
		cpu.io_wr(`TMR16_A_CTRL_A, 8'hf0);
		cpu.io_wr(`TMR16_A_CTRL_B, 8'h18);
		rdc("ctrl_a rw", `TMR16_A_CTRL_A, 8'hf0);
		rdc("ctrl_b rw", `TMR16_A_CTRL_B, 8'h18);
		cpu.io_wr(`TMR16_A_CTRL_A, 8'h00);
		cpu.io_wr(`TMR16_A_CTRL_B, 8'h00);
		$display("t_bytes done");
	endtask

	// Each internal clock select over 4096 cycles; slack covers enable latency
	task automatic t_clocks();
		int dv[5] = '{1, 8, 64, 256, 1024};
		tmr16_word_t w2;
		for (int i = 0; i < 5; i++) begin
			cpu.wr16(`TMR16_A_CNT_L, 16'h0000);
			cpu.io_wr(`TMR16_A_CTRL_B, 8'(i + 1));
			run(4096);
			cpu.io_wr(`TMR16_A_CTRL_B, 8'h00);
			cpu.rd16(`TMR16_A_CNT_L, w);
			chkr("ticks", 4096 / dv[i] - 1, 4101 / dv[i] + 1, w);
		end
		run(200);
		cpu.rd16(`TMR16_A_CNT_L, w2);
		chk("stopped", w, w2);
		$display("t_clocks done");
	endtask

	task automatic t_ext();
		cpu.wr16(`TMR16_A_CNT_L, 16'h0000);
		cpu.io_wr(`TMR16_A_CTRL_B, 8'h07);
		repeat (5) begin
			ext_pin <= 1'b1;
			run(4);
			ext_pin <= 1'b0;
			run(4);
		end
		cpu.io_wr(`TMR16_A_CTRL_B, 8'h06);
		repeat (3) begin
			ext_pin <= 1'b1;
			run(4);
			ext_pin <= 1'b0;
			run(4);
		end
		cpu.io_wr(`TMR16_A_CTRL_B, 8'h00);
		cpu.rd16(`TMR16_A_CNT_L, w);
		chk("ext edges", 16'h0008, w);
		$display("t_ext done");
	endtask

	task automatic t_match();
		cpu.wr16(`TMR16_A_CMPA_L, 16'h0010);
		cpu.wr16(`TMR16_A_CMPB_L, 16'h0020);
		cpu.wr16(`TMR16_A_CNT_L, 16'h0015);
		run(2);
		chk("wave a", 16'h0000, wave_a);
		chk("wave b", 16'h0001, wave_b);
		cpu.wr16(`TMR16_A_CNT_L, 16'h0000);
		cpu.io_wr(`TMR16_A_FLAG, 8'hff);
		cpu.io_wr(`TMR16_A_CTRL_B, 8'h01);
		run(60);
		cpu.io_wr(`TMR16_A_CTRL_B, 8'h00);
		rdc("match flags", `TMR16_A_FLAG, 8'h60);
		chk("irq masked", 16'h0000, irq);
		cpu.io_wr(`TMR16_A_MASK, 8'h20);
		run(2);
		chk("irq b", 16'h0001, irq);
		cpu.io_wr(`TMR16_A_FLAG, 8'h20);
		run(2);
		chk("irq cleared", 16'h0000, irq);
		cpu.wr16(`TMR16_A_CNT_L, 16'hfff0);
		cpu.io_wr(`TMR16_A_CTRL_B, 8'h01);
		run(20);
		cpu.io_wr(`TMR16_A_CTRL_B, 8'h00);
		rdc("overflow", `TMR16_A_FLAG, 8'hc0);
		chk("wave wrapped", 16'h0001, wave_a);
		cpu.io_wr(`TMR16_A_MASK, 8'h80);
		run(2);
		chk("irq ovf", 16'h0001, irq);
		cpu.io_wr(`TMR16_A_MASK, 8'h00);
		cpu.io_wr(`TMR16_A_FLAG, 8'hff);
		$display("t_match done");
	endtask

	// Pin, then comparator; the filter must swallow a two-cycle spike
	task automatic t_capture();
		cpu.wr16(`TMR16_A_CNT_L, 16'h4321);
		cpu.io_wr(`TMR16_A_CTRL_B, 8'h40);
		capt_pin <= 1'b1;
		run(8);
		capt_pin <= 1'b0;
		cpu.rd16(`TMR16_A_CAPT_L, w);
		chk("pin capture", 16'h4321, w);
		rdc("capt flag", `TMR16_A_FLAG, 8'h08);
		src_comp <= 1'b1;
		cpu.wr16(`TMR16_A_CNT_L, 16'h2468);
		comp_out <= 1'b1;
		run(8);
		comp_out <= 1'b0;
		cpu.io_wr(`TMR16_A_CTRL_B, 8'hc0);
		cpu.wr16(`TMR16_A_CNT_L, 16'h1357);
		comp_out <= 1'b1;
		run(2);
		comp_out <= 1'b0;
		run(8);
		cpu.rd16(`TMR16_A_CAPT_L, w);
		chk("spike ignored", 16'h2468, w);
		comp_out <= 1'b1;
		run(12);
		comp_out <= 1'b0;
		cpu.rd16(`TMR16_A_CAPT_L, w);
		chk("filtered capture", 16'h1357, w);
		src_comp <= 1'b0;
		cpu.io_wr(`TMR16_A_CTRL_B, 8'h00);
		$display("t_capture done");
	endtask

	// Counter must never pass the TOP of each mode within 1100 cycles
	task automatic t_top();
		tmr16_byte_t ma[5] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h00};
		tmr16_byte_t mb[5] = '{8'h08, 8'h08, 8'h08, 8'h08, 8'h18};
		int tp[5] = '{9, 255, 511, 1023, 7};
		cpu.wr16(`TMR16_A_CMPA_L, 16'h0009);
		cpu.io_wr(`TMR16_A_CTRL_B, 8'h18);
		cpu.wr16(`TMR16_A_CAPT_L, 16'h0007);
		for (int i = 0; i < 5; i++) begin
			cpu.wr16(`TMR16_A_CNT_L, 16'h0000);
			cpu.io_wr(`TMR16_A_CTRL_A, ma[i]);
			cpu.io_wr(`TMR16_A_CTRL_B, mb[i] | 8'h01);
			run(1100);
			cpu.io_wr(`TMR16_A_CTRL_B, mb[i]);
			cpu.rd16(`TMR16_A_CNT_L, w);
			chkr("top", 0, tp[i], w);
		end
		cpu.io_wr(`TMR16_A_CTRL_A, 8'h03);
		cpu.wr16(`TMR16_A_CNT_L, 16'h0000);
		run(2);
		chk("top no pwm", 16'h0000, wave_a);
		cpu.io_wr(`TMR16_A_CTRL_A, 8'h00);
		cpu.io_wr(`TMR16_A_CTRL_B, 8'h00);
		$display("t_top done");
	endtask

	// ----------------------------------------------------------
	// Sequence and hang guard
	// ----------------------------------------------------------
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == LIMIT) begin
			err_total++;
			$display("MISMATCH run length expected %0d seen %0d", LIMIT, cycles);
			finish_test();
		end
	end

	initial begin
		run(4);
		rst_b <= 1'b1;
		t_reset();
		t_presc();
		t_bytes();
		t_clocks();
		t_ext();
		t_match();
		t_capture();
		t_top();
		finish_test();
	end
endmodule

// ---- verification/tmr16_cpu_model.sv ----
/*
 Behavioural 8-bit CPU on the timer's I/O port: byte and 16-bit access tasks.
 Assumes one caller thread and the single-cycle strobe timing of the core.
*/
`timescale 1ns/100ps
`include "tmr16_defines.svh"

module tmr16_cpu_model (
	input  wire logic                     i_clk,
	input  wire tmr16_pkg::tmr16_byte_t   i_rdata,
	output logic [`TMR16_ADDR_W-1:0]      o_addr,
	output logic                          o_wr,
	output logic                          o_rd,
	output tmr16_pkg::tmr16_byte_t        o_wdata
);
	import tmr16_pkg::*;

	// Idle bus at time zero
	initial begin
		o_addr = 6'h3f;
		o_wr = 1'b0;
		o_rd = 1'b0;
		o_wdata = 8'h00;
	end

	// ----------------------------------------------------------
	// Byte cycles
	// ----------------------------------------------------------
	// After release the lines invert, so a stale value never looks valid
	task automatic io_wr(input logic [5:0] a, input tmr16_byte_t d);
		@(posedge i_clk);
		o_addr <= a;
		o_wdata <= d;
		o_wr <= 1'b1;
		@(posedge i_clk);
		o_wr <= 1'b0;
		o_addr <= ~a;
		o_wdata <= ~d;
	endtask

	// Data taken once the registered answer has settled
	task automatic io_rd(input logic [5:0] a, output tmr16_byte_t d);
		@(posedge i_clk);
		o_addr <= a;
		o_rd <= 1'b1;
		@(posedge i_clk);
		o_rd <= 1'b0;
		o_addr <= ~a;
		@(negedge i_clk);
		d = i_rdata;
	endtask

	// ----------------------------------------------------------
	// Two-byte cycles, never interleaved with another access
	// ----------------------------------------------------------
	task automatic wr16(input logic [5:0] a_lo, input tmr16_word_t v);
		io_wr(a_lo + 6'h01, v[15:8]);
		io_wr(a_lo, v[7:0]);
	endtask

	task automatic rd16(input logic [5:0] a_lo, output tmr16_word_t v);
		io_rd(a_lo, v[7:0]);
		io_rd(a_lo + 6'h01, v[15:8]);
	endtask
endmodule
